/* File: rtl/gdmas_pkg.sv */
// Package with register map, commands, field layouts and shared types of the DMA slave.
package gdmas_pkg;
  // Register byte addresses.
  localparam logic [7:0] OFF_COMMAND = 8'h30;
  localparam logic [7:0] OFF_COUNTER = 8'h34;
  localparam logic [7:0] OFF_CONFIG = 8'h38;
  localparam logic [7:0] OFF_HARDWARE = 8'h3C;
  localparam logic [7:0] OFF_STATUS = 8'h40;
  localparam logic [7:0] OFF_BUFFER = 8'h44;
  // Command codes.
  localparam logic [7:0] CMD_IN_XFER = 8'h00;
  localparam logic [7:0] CMD_OUT_XFER = 8'h01;
  localparam logic [7:0] CMD_VALIDATE = 8'h0E;
  localparam logic [7:0] CMD_CLEAR = 8'h0F;
  localparam logic [7:0] CMD_RESET = 8'h11;
  localparam logic [7:0] CMD_STOP = 8'h13;
  // Reset and read values.
  localparam logic [7:0] COMMAND_READ = 8'hFF;
  localparam logic [15:0] CONFIG_RESET = 16'h0001;
  localparam logic [7:0] HARDWARE_RESET = 8'h00;
  localparam logic [31:0] COUNTER_RESET = 32'h0000_0000;
  // Field positions.
  localparam int CFG_WIDTH_BIT = 0;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_CNT_DIS_BIT = 7;
  localparam int HW_ACKNOWLEDGE_POLARITY_BIT = 0;
  localparam int HW_REQ_POL_BIT = 1;
  localparam int ST_COMPLETE_BIT = 0;
  localparam int ST_EOT_BIT = 1;
  localparam int ST_STOP_BIT = 2;
  localparam int ST_ACTIVE_BIT = 3;
  localparam int ST_DIR_BIT = 4;
  localparam int ST_BUSON_BIT = 5;
  localparam int ST_CFGSEEN_BIT = 6;
  localparam logic [1:0] MODE_STD = 2'b00;
  // Cycles the core-reset command holds the handshake pins busy.
  localparam logic [1:0] CORE_RESET_CYCLES = 2'd2;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    GDMAS_IDLE,
    GDMAS_RUN,
    GDMAS_RESET
  } gdmas_state_t;

  // Pins facing the external DMA bus.
  typedef struct packed {
    logic req;
    logic [15:0] data_o;
    logic data_oe;
  } gdmas_pins_t;

  // Complete state of the block.
  typedef struct packed {
    gdmas_state_t st;
    logic dir_out;
    logic [23:0] shadow;
    logic [31:0] count;
    logic [15:0] cfg;
    logic [7:0] hw;
    logic cfg_seen;
    logic bus_on;
    logic complete;
    logic internal_transfer_end;
    logic stopped;
    logic tx_valid;
    logic [1:0] tx_full;
    logic [1:0] rst_cnt;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic wr_evt;
    logic rd_evt;
    logic aw_ok;
    logic w_ok;
    logic [7:0] aw;
    logic [31:0] w;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rd;
    logic [1:0] rresp;
    logic [2:0] rd_s;
    logic [2:0] wr_s;
    logic [2:0] ack_s;
  } gdmas_state_vec_t;
endpackage

/* File: rtl/gdmas_core.sv */
// Generic DMA slave: command decode, byte counter, termination flags, bus drive.
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1 - Command 00h starts an IN transfer, DMA bus data into endpoint buffer.
// R2 - Command 01h starts an OUT transfer, endpoint buffer data onto DMA bus.
// R3 - Shared strobes go to DMA engine during transfers, to registers otherwise.
// R4 - Software keeps the counter disable bit at zero for counter mode.
// R5 - Software loads the counter before commands, bytes 34h to 37h, LSB first.
// R6 - Working counter takes the written value only when the top byte is written.
// R7 - Counter decrements per byte; at zero the complete flag sets.
// R8 - A transfer starts as soon as its command is written.
// R9 - Besides completion, transfers end on internal end, reset command or stop.
// R10 - Internal end and completion are reported by separate flags.
// R11 - Data bus stays undriven until a command runs; other outputs always driven.
// R12 - Command register is a write-only byte and reads back FFh.
// R13 - Command 0Eh marks the endpoint buffer valid for USB transmission.
// R14 - Command 0Fh empties the transmit buffer, receive buffer untouched.
// R15 - Transmit buffer empties by itself once its data is sent on USB.
// R16 - Each clear empties one buffer; double buffering needs two clears.
// R17 - Command 11h returns the whole DMA core to its power-on state; here tx_full and tx_valid keep their values.
// R18 - During the reset command handshake outputs may briefly assert.
// R19 - The external controller starts only after the reset command completes.
// R20 - Command 13h halts the transfer, keeps buffer data and sets a flag.
// R21 - A mode field selects the active strobes for data transfer.
// R22 - Width bit picks 16 or 8 bit bus; polarity bits set request, acknowledge.
// R23 - Counter is 32 bits and reads back the bytes still to go.
// R24 - Mode 00 uses write strobe to latch, read strobe to drive; others reserved.
// R25 - Width 0 is 8 bits, 1 is 16 bits, reset value 1.
// R26 - Request output stays inactive until the config register has been written.
// R27 - Reserved command codes are ignored without touching any state.
// R28 - Request asserts while data or space exists; each strobe decrements counter.
//
// Chosen here: the AXI4-Lite slave port.
module gdmas_core (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External DMA pins.
  input wire logic dma_acknowledge_in,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [15:0] dma_data_i,
  output logic dma_request_out,
  output logic [15:0] dma_data_o,
  output logic dma_data_oe,
  // Endpoint buffer side.
  input wire logic ep_space_avail,
  input wire logic ep_data_avail,
  input wire logic ep_short_packet,
  input wire logic usb_tx_sent,
  input wire logic [15:0] ep_rd_data,
  output logic [15:0] ep_wr_data,
  output logic ep_wr_pulse,
  output logic ep_rd_pulse,
  output logic ep_validate,
  output logic ep_tx_clear,
  output logic pio_rd_strobe_n,
  output logic pio_wr_strobe_n
);
  gdmas_pkg::gdmas_state_vec_t q, d;
  gdmas_pkg::gdmas_pins_t pins;
  logic running, wide, mode_ok, ack_act, rd_fall, wr_fall, xfer;
  logic do_w, do_r, top_w;
  logic [7:0] cmd;
  logic [31:0] step;
  logic [31:0] rmux;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded levels.
  assign running = (q.st == gdmas_pkg::GDMAS_RUN);
  assign wide = q.cfg[gdmas_pkg::CFG_WIDTH_BIT]; // R22 R25
  assign mode_ok = (q.cfg[gdmas_pkg::CFG_MODE_LSB +: 2] == gdmas_pkg::MODE_STD); // R21 R24
  assign ack_act = (q.ack_s[1] == q.hw[gdmas_pkg::HW_ACKNOWLEDGE_POLARITY_BIT]); // R22
  assign rd_fall = (q.rd_s[2:1] == 2'b10);
  assign wr_fall = (q.wr_s[2:1] == 2'b10);
  assign xfer = running && mode_ok && ack_act &&
    (q.dir_out ? rd_fall : wr_fall); // R24 R28
  assign step = wide ? 32'h0000_0002 : 32'h0000_0001; // R7 R28
  assign do_w = q.aw_ok && q.w_ok && !q.bvalid;
  assign do_r = s_axi_arvalid && !q.rvalid;
  assign top_w = do_w && (q.aw == gdmas_pkg::OFF_COUNTER) && q.ws[3];
  assign cmd = q.w[7:0];

  always_comb begin
    unique case (s_axi_araddr)
      gdmas_pkg::OFF_COMMAND: rmux = {24'h00_0000, gdmas_pkg::COMMAND_READ}; // R12
      gdmas_pkg::OFF_COUNTER: rmux = q.count; // R23
      gdmas_pkg::OFF_CONFIG: rmux = {16'h0000, q.cfg};
      gdmas_pkg::OFF_HARDWARE: rmux = {24'h00_0000, q.hw};
      gdmas_pkg::OFF_STATUS: rmux = {25'h000_0000, q.cfg_seen, q.bus_on, q.dir_out,
        running, q.stopped, q.internal_transfer_end, q.complete};
      gdmas_pkg::OFF_BUFFER: rmux = {29'h0000_0000, q.tx_full, q.tx_valid};
      default: rmux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    d = q;
    d.rd_s = {q.rd_s[1:0], read_strobe_n};
    d.wr_s = {q.wr_s[1:0], write_strobe_n};
    d.ack_s = {q.ack_s[1:0], dma_acknowledge_in};
    d.wr_evt = 1'b0;
    d.rd_evt = 1'b0;
    // Write address and data channels, taken in either order.
    if (s_axi_awvalid && !q.aw_ok) begin
      d.aw_ok = 1'b1;
      d.aw = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_ok) begin
      d.w_ok = 1'b1;
      d.w = s_axi_wdata;
      d.ws = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (do_r) begin
      d.rvalid = 1'b1;
      d.rd = rmux;
      d.rresp = (s_axi_araddr inside {gdmas_pkg::OFF_COMMAND, gdmas_pkg::OFF_COUNTER,
        gdmas_pkg::OFF_CONFIG, gdmas_pkg::OFF_HARDWARE, gdmas_pkg::OFF_STATUS,
        gdmas_pkg::OFF_BUFFER}) ? gdmas_pkg::RESP_OKAY : gdmas_pkg::RESP_SLVERR;
      if (s_axi_araddr == gdmas_pkg::OFF_STATUS) begin
        d.complete = 1'b0;
        d.internal_transfer_end = 1'b0;
        d.stopped = 1'b0;
      end
    end
    // Data strobes on the DMA side.
    if (xfer) begin // R3 R28
      if (q.count <= step) begin
        d.count = 32'h0000_0000;
        d.complete = 1'b1; // R7 R10
        d.st = gdmas_pkg::GDMAS_IDLE;
      end else begin
        d.count = q.count - step; // R7
      end
      if (q.dir_out) begin
        d.rd_evt = 1'b1; // R2
      end else begin
        d.wdata = wide ? dma_data_i : {8'h00, dma_data_i[7:0]};
        d.wr_evt = 1'b1; // R1
      end
    end
    if (q.dir_out) begin
      d.rdata = ep_rd_data;
    end
    if (running && q.dir_out && ep_short_packet) begin
      d.internal_transfer_end = 1'b1; // R9 R10
      d.st = gdmas_pkg::GDMAS_IDLE;
    end
    if (usb_tx_sent && q.tx_full != 2'b00) begin
      d.tx_full = q.tx_full - 2'b01; // R15
      d.tx_valid = (q.tx_full != 2'b01);
    end
    if (q.st == gdmas_pkg::GDMAS_RESET) begin
      d.rst_cnt = q.rst_cnt - 2'b01; // R18
      if (q.rst_cnt == 2'b01) begin
        d.st = gdmas_pkg::GDMAS_IDLE;
      end
    end
    // Register writes.
    if (do_w) begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = gdmas_pkg::RESP_OKAY;
      unique case (q.aw)
        gdmas_pkg::OFF_COMMAND: begin
          if (q.ws[0]) begin
            unique case (cmd)
              gdmas_pkg::CMD_IN_XFER, gdmas_pkg::CMD_OUT_XFER: begin
                d.st = gdmas_pkg::GDMAS_RUN; // R8
                d.dir_out = (cmd == gdmas_pkg::CMD_OUT_XFER); // R1 R2
                d.bus_on = 1'b1; // R11
              end
              gdmas_pkg::CMD_VALIDATE: begin
                d.tx_valid = 1'b1; // R13
                d.tx_full = (q.tx_full == 2'b10) ? 2'b10 : q.tx_full + 2'b01;
              end
              gdmas_pkg::CMD_CLEAR: begin
                if (q.tx_full != 2'b00) begin
                  d.tx_full = q.tx_full - 2'b01; // R14 R16
                end
                d.tx_valid = (q.tx_full == 2'b10);
              end
              gdmas_pkg::CMD_RESET: begin
                d.st = gdmas_pkg::GDMAS_RESET; // R17 R9
                d.rst_cnt = gdmas_pkg::CORE_RESET_CYCLES;
                d.count = gdmas_pkg::COUNTER_RESET;
                d.shadow = 24'h00_0000;
                d.cfg = gdmas_pkg::CONFIG_RESET;
                d.hw = gdmas_pkg::HARDWARE_RESET;
                d.cfg_seen = 1'b0;
                d.bus_on = 1'b0;
                d.complete = 1'b0;
                d.internal_transfer_end = 1'b0;
                d.stopped = 1'b0;
                d.dir_out = 1'b0;
              end
              gdmas_pkg::CMD_STOP: begin
                if (running) begin
                  d.st = gdmas_pkg::GDMAS_IDLE; // R9 R20
                  d.stopped = 1'b1; // R20
                end
              end
              default: begin
              end // R27
            endcase
          end
        end
        gdmas_pkg::OFF_COUNTER: begin
          if (q.ws[0]) d.shadow[7:0] = q.w[7:0];
          if (q.ws[1]) d.shadow[15:8] = q.w[15:8];
          if (q.ws[2]) d.shadow[23:16] = q.w[23:16];
          if (top_w) begin
            d.count = {q.w[31:24], (q.ws[2] ? q.w[23:16] : q.shadow[23:16]),
              (q.ws[1] ? q.w[15:8] : q.shadow[15:8]),
              (q.ws[0] ? q.w[7:0] : q.shadow[7:0])}; // R5 R6
          end
        end
        gdmas_pkg::OFF_CONFIG: begin
          if (q.ws[0]) d.cfg[7:0] = q.w[7:0];
          if (q.ws[1]) d.cfg[15:8] = q.w[15:8];
          d.cfg_seen = 1'b1; // R26
        end
        gdmas_pkg::OFF_HARDWARE: begin
          if (q.ws[0]) d.hw = q.w[7:0];
        end
        gdmas_pkg::OFF_STATUS, gdmas_pkg::OFF_BUFFER: begin
        end
        default: d.bresp = gdmas_pkg::RESP_SLVERR;
      endcase
    end
    // Event flags keep their set over a same-cycle status read.
    if (xfer && q.count <= step) d.complete = 1'b1;
    if (running && q.dir_out && ep_short_packet) d.internal_transfer_end = 1'b1;
    if (!aresetn) begin
      d = '0;
      d.st = gdmas_pkg::GDMAS_IDLE;
      d.cfg = gdmas_pkg::CONFIG_RESET;
      d.hw = gdmas_pkg::HARDWARE_RESET;
      d.count = gdmas_pkg::COUNTER_RESET;
      d.rd_s = 3'b111;
      d.wr_s = 3'b111;
      d.ack_s = {3{!gdmas_pkg::HARDWARE_RESET[gdmas_pkg::HW_ACKNOWLEDGE_POLARITY_BIT]}};
    end
  end

  always_ff @(posedge aclk) begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  always_comb begin
    pins.req = q.hw[gdmas_pkg::HW_REQ_POL_BIT] ? 1'b1 : 1'b0;
    if (q.st == gdmas_pkg::GDMAS_RESET) begin
      pins.req = !q.hw[gdmas_pkg::HW_REQ_POL_BIT]; // R18
    end else if (q.cfg_seen && running && mode_ok &&
      (q.dir_out ? ep_data_avail : ep_space_avail)) begin
      pins.req = !q.hw[gdmas_pkg::HW_REQ_POL_BIT]; // R26 R28
    end
    pins.data_o = wide ? q.rdata : {8'h00, q.rdata[7:0]};
    pins.data_oe = q.bus_on && q.dir_out && running && !read_strobe_n; // R11
  end

  assign dma_request_out = pins.req;
  assign dma_data_o = pins.data_o;
  assign dma_data_oe = pins.data_oe;
  assign ep_wr_data = q.wdata;
  assign ep_wr_pulse = q.wr_evt;
  assign ep_rd_pulse = q.rd_evt;
  assign ep_validate = q.tx_valid;
  assign ep_tx_clear = (q.tx_full == 2'b00);
  assign pio_rd_strobe_n = running ? 1'b1 : read_strobe_n; // R3
  assign pio_wr_strobe_n = running ? 1'b1 : write_strobe_n; // R3
  assign s_axi_awready = !q.aw_ok;
  assign s_axi_wready = !q.w_ok;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rd;
  assign s_axi_rresp = q.rresp;
endmodule

/* File: sim/gdmas_core_assertions.sv */
// Concurrent checks on the ports of the DMA slave core, bound to it.
module gdmas_chk (
  // Clock and reset.
  input logic aclk,
  input logic aresetn,
  // Register bus.
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // DMA and endpoint side.
  input logic dma_request_out,
  input logic dma_data_oe,
  input logic ep_wr_pulse,
  input logic ep_rd_pulse,
  input logic pio_rd_strobe_n,
  input logic pio_wr_strobe_n
);
  logic cmd_q;
  logic cfg_q;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  // Remember whether a command or a configuration write was ever taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_q <= 1'b0;
      cfg_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      if (s_axi_awaddr == 8'h30) cmd_q <= 1'b1;
      if (s_axi_awaddr == 8'h38) cfg_q <= 1'b1;
    end
  end
  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_cmd_read;
    s_read_taken ##0 s_axi_araddr == 8'h30;
  endsequence
  a_bus_quiet: assert property (!cmd_q |-> !dma_data_oe)
    else $error("Data bus driven before any command.");
  a_req_held: assert property (!cfg_q |-> !dma_request_out)
    else $error("Request driven before configuration.");
  a_cmd_reads_ff: assert property (s_cmd_read |=> s_axi_rvalid && s_axi_rdata[7:0] == 8'hFF)
    else $error("Command register did not read back all ones.");
  a_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
    else $error("Read answer missing.");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read answer repeated.");
  a_wr_pulse_one: assert property (ep_wr_pulse |=> !ep_wr_pulse)
    else $error("Buffer write pulse too long.");
  a_rd_pulse_one: assert property (ep_rd_pulse |=> !ep_rd_pulse)
    else $error("Buffer read pulse too long.");
  a_dir_apart: assert property (ep_rd_pulse || dma_data_oe |-> !ep_wr_pulse)
    else $error("Both directions moved at once.");
  a_pio_blocked: assert property (dma_data_oe |-> pio_rd_strobe_n && pio_wr_strobe_n)
    else $error("Register strobes passed during a transfer.");
endmodule
bind gdmas_core gdmas_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .dma_request_out(dma_request_out), .dma_data_oe(dma_data_oe),
  .ep_wr_pulse(ep_wr_pulse), .ep_rd_pulse(ep_rd_pulse),
  .pio_rd_strobe_n(pio_rd_strobe_n), .pio_wr_strobe_n(pio_wr_strobe_n));

/* File: sim/gdmas_dma_ext.sv */
// Model of the external DMA controller: acknowledge, strobes and data.
module gdmas_dma_ext (
  // Clock and reset.
  input logic aclk,
  input logic aresetn,
  // Bench control.
  input logic en,
  input logic use_rd,
  // Device side.
  input logic req,
  input logic [15:0] bus,
  output logic ack_n = 1'b1,
  output logic rd_n = 1'b1,
  output logic wr_n = 1'b1,
  output logic [15:0] drv = 16'h0,
  output logic [15:0] got,
  output int cnt = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ph = 4'h0;
  ////////////////////////////////////////////////////////////////////////
  // One word per request: strobe low seven cycles, then a quiet gap.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ph <= 4'h0;
      ack_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      cnt <= 0;
    end else if (ph != 4'h0) begin
      ph <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
      if (ph > 4'h7) drv <= ~drv;
      if (ph == 4'h7) begin
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        cnt <= cnt + 1;
        if (use_rd) got <= bus;
      end
      if (ph == 4'hB) ack_n <= 1'b1;
    end else if (en && req) begin
      ph <= 4'h1;
      ack_n <= 1'b0;
      rd_n <= !use_rd;
      wr_n <= use_rd;
      drv <= 16'hA5C3 ^ cnt[15:0];
    end else begin
      drv <= ~drv;
    end
  end
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the generic DMA slave core.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] a;
    logic [3:0] s;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } gdmas_row_t;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, en = 1'b0, use_rd = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic dma_acknowledge_in, read_strobe_n, write_strobe_n, dma_request_out, dma_data_oe;
  logic [15:0] dma_data_o, drv, got, ep_wr_data, lastw, ep_rd_data = 16'h3C5A;
  logic ep_space_avail = 1'b1, ep_data_avail = 1'b1, ep_short_packet = 1'b0;
  logic usb_tx_sent = 1'b0, ep_wr_pulse, ep_rd_pulse, ep_tx_clear, ep_validate;
  logic [1:0] wresp;
  int cnt, nwr = 0, nrd = 0, miscompares = 0, cmp_count = 0;
  wire [15:0] dma_data_i = dma_data_oe ? dma_data_o : drv;
  gdmas_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .dma_acknowledge_in, .read_strobe_n, .write_strobe_n, .dma_data_i,
    .dma_request_out, .dma_data_o, .dma_data_oe, .ep_space_avail, .ep_data_avail,
    .ep_short_packet, .usb_tx_sent, .ep_rd_data, .ep_wr_data, .ep_wr_pulse, .ep_rd_pulse,
    .ep_validate, .ep_tx_clear, .pio_rd_strobe_n(), .pio_wr_strobe_n());
  gdmas_dma_ext ext (.aclk, .aresetn, .en, .use_rd, .req(dma_request_out), .bus(dma_data_i),
    .ack_n(dma_acknowledge_in), .rd_n(read_strobe_n), .wr_n(write_strobe_n), .drv, .got, .cnt);
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    if (ep_wr_pulse) begin
      nwr <= nwr + 1;
      lastw <= ep_wr_data;
    end
    if (ep_rd_pulse) nrd <= nrd + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tmo;
    $display("Error at %0t: wait ran out", $time);
    miscompares++;
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      miscompares++;
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, w, b;
    int n;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !b; n++) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      if (b) wresp = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
    if (!b) tmo();
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    int n;
    v = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && !v; n++) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (v) s_axi_rready <= 1'b0;
    end
    if (!v) tmo();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d & m, e);
  endtask
  task automatic cmd(input logic [7:0] c);
    axi_wr(8'h30, {24'h0, c}, 4'h1);
  endtask
  task automatic wait_cnt(input int k);
    int n;
    for (n = 0; n < 400 && cnt < k; n++) @(posedge aclk);
    if (cnt < k) tmo();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    gdmas_row_t rows[6];
    logic [31:0] d;
    logic [1:0] r;
    int i;
    rows = '{'{8'h30, 4'h0, 32'h0, 32'hFF, 2'h0}, '{8'h38, 4'h0, 32'h0, 32'h1, 2'h0},
      '{8'h34, 4'h7, 32'h10, 32'h0, 2'h0}, '{8'h34, 4'h8, 32'h0, 32'h10, 2'h0},
      '{8'h30, 4'h1, 32'h55, 32'hFF, 2'h0}, '{8'h50, 4'h0, 32'h0, 32'h0, 2'h2}};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(dma_data_oe, 32'h0);
    chk(dma_request_out, 32'h0);
    for (i = 0; i < 6; i++) begin
      if (rows[i].s != 4'h0) axi_wr(rows[i].a, rows[i].d, rows[i].s);
      axi_rd(rows[i].a, d, r);
      chk(r, rows[i].r);
      if (r === 2'h0) chk(d, rows[i].e);
    end
    // Inbound transfer of two 16-bit words.
    axi_wr(8'h38, 32'h1, 4'hF);
    axi_wr(8'h34, 32'h4, 4'hF);
    cmd(8'h00);
    rdc(8'h40, 32'h8, 32'h8);
    en <= 1'b1;
    wait_cnt(2);
    repeat (12) @(posedge aclk);
    chk(nwr, 32'h2);
    chk(lastw, 32'hA5C2);
    chk(dma_request_out, 32'h0);
    rdc(8'h40, 32'hF, 32'h1);
    rdc(8'h34, 32'hFFFFFFFF, 32'h0);
    // Outbound transfer cut short by a short packet.
    axi_wr(8'h34, 32'h64, 4'hF);
    use_rd <= 1'b1;
    cmd(8'h01);
    wait_cnt(3);
    ep_short_packet <= 1'b1;
    en <= 1'b0;
    @(posedge aclk);
    ep_short_packet <= 1'b0;
    repeat (12) @(posedge aclk);
    chk(got, 32'h3C5A);
    chk(nrd, 32'h1);
    rdc(8'h40, 32'hF, 32'h2);
    rdc(8'h34, 32'hFFFFFFFF, 32'h62);
    // Reserved code during a transfer, then stop.
    cmd(8'h00);
    cmd(8'h12);
    chk(wresp, 32'h0);
    rdc(8'h40, 32'hF, 32'h8);
    cmd(8'h13);
    rdc(8'h40, 32'hF, 32'h4);
    // Core reset while a transfer runs.
    cmd(8'h00);
    cmd(8'h11);
    repeat (4) @(posedge aclk);
    rdc(8'h34, 32'hFFFFFFFF, 32'h0);
    rdc(8'h40, 32'h48, 32'h0);
    chk(dma_request_out, 32'h0);
    // Buffer validate, clear and automatic emptying.
    cmd(8'h0E);
    cmd(8'h0E);
    rdc(8'h44, 32'h6, 32'h4);
    chk(ep_validate, 32'h1);
    cmd(8'h0F);
    rdc(8'h44, 32'h6, 32'h2);
    @(posedge aclk);
    usb_tx_sent <= 1'b1;
    @(posedge aclk);
    usb_tx_sent <= 1'b0;
    rdc(8'h44, 32'h6, 32'h0);
    chk(ep_tx_clear, 32'h1);
    print_verdict();
  end
endmodule
